// [dic_regs.sv]
// Identity and capability register bank with masked clock gating.
// Assumes a classic Wishbone master, byte addresses, 32-bit data.
//
// Overview of operation
// [RULE1] Identity word top nibble reports the register layout version.
// [RULE2] Identity word bits 27:24 report a fixed family code.
// [RULE3] Identity word bits 23:16 report the fixed part number code.
// [RULE4] Reserved bits are undefined for software, which must leave them.
// [RULE5] Temperature grade field reads 1, the industrial range.
// [RULE6] Package field reads 1, the 48-pin quad flat package.
// [RULE7] Compliance bit reads 1 for hazardous-substance compliant parts.
// [RULE8] Qualification: 00 sample, 01 pilot, 10 qualified, 11 reserved.
// [RULE9] Memory capability upper half reports SRAM size, 000F is 4 KB.
// [RULE10] Memory capability lower half reports flash size, 0007 is 16 KB.
// [RULE11] Feature bit 20 flags the PWM module, bit 16 the converter.
// [RULE12] Bits 15:12 give minimum clock divider, 7 means 25 MHz.
// [RULE13] Bits 11:8 give maximum sample rate, 1 means 250K per second.
// [RULE14] Bit 7 reads 1 when the memory protection unit exists.
// [RULE15] Bits 5, 4, 3 flag temperature sensor, PLL and watchdog.
// [RULE16] Bits 2, 1, 0 flag trace port, two-wire debug and JTAG.
// [RULE17] Marked capability bits mask run, sleep and deep-sleep gating.
// [RULE18] Gating positions without a marked capability bit pass as 0.
// [RULE19] Converter speed setting is clipped to the maximum sample rate.
// [RULE20] Writes to identity and capability words change nothing.
`timescale 1ns/1ps
module dic_regs
   import dic_pkg::*;
#(
   parameter logic [3:0] FAMILY = 4'h5, // Arbitrary value
   parameter logic [7:0] PART = 8'h3C, // Arbitrary value
   parameter logic [1:0] QUALIFICATION_STATUS = QUALIFICATION_STATUS_FULL,
   parameter logic [15:0] SRAM_SIZE = SRAM_4KB,
   parameter logic [15:0] FLASH_SIZE = FLASH_16KB,
   parameter logic [3:0] MIN_DIV = MIN_DIV_25MHZ,
   parameter logic [3:0] MAX_RATE = MAX_RATE_250K,
   parameter bit HAS_PWM = 1'b1,
   parameter bit HAS_ADC = 1'b1,
   parameter bit HAS_MPU = 1'b1,
   parameter bit HAS_TSENSE = 1'b1,
   parameter bit HAS_PLL = 1'b1,
   parameter bit HAS_WDOG = 1'b1,
   parameter bit HAS_TRACE = 1'b1,
   parameter bit HAS_SWD = 1'b1,
   parameter bit HAS_JTAG = 1'b1
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [SEL_W-1:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   output logic [DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Effective clock-gating words
   output dic_gate_s gate_o
);

   // ----------------------------------------------------------------
   // Fixed words
   // ----------------------------------------------------------------
   dic_identity_s id_word;
   dic_memsize_s mem_word;
   dic_feature_s feat_word;

   always_comb begin
      id_word = '0; // [RULE4]
      id_word.format_version = FORMAT_VERSION; // [RULE1]
      id_word.family_code = FAMILY; // [RULE2]
      id_word.part_number_code = PART; // [RULE3]
      id_word.temp_grade = TEMP_INDUSTRIAL; // [RULE5]
      id_word.package_code = PKG_QFP48; // [RULE6]
      id_word.substance_compliance_flag = 1'b1; // [RULE7]
      id_word.qualification_status = QUALIFICATION_STATUS; // [RULE8]
   end

   always_comb begin
      mem_word.sram_size = SRAM_SIZE; // [RULE9]
      mem_word.flash_size = FLASH_SIZE; // [RULE10]
   end

   always_comb begin
      feat_word = '0; // [RULE4]
      feat_word.pwm_present = HAS_PWM; // [RULE11]
      feat_word.adc_present = HAS_ADC; // [RULE11]
      feat_word.min_sysclk_divider = MIN_DIV; // [RULE12]
      feat_word.max_sample_rate = MAX_RATE; // [RULE13]
      feat_word.mpu_present = HAS_MPU; // [RULE14]
      feat_word.temp_sensor_present = HAS_TSENSE; // [RULE15]
      feat_word.pll_present = HAS_PLL; // [RULE15]
      feat_word.watchdog_present = HAS_WDOG; // [RULE15]
      feat_word.trace_port_present = HAS_TRACE; // [RULE16]
      feat_word.swd_port_present = HAS_SWD; // [RULE16]
      feat_word.jtag_port_present = HAS_JTAG; // [RULE16]
   end

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic req;
   logic wr_stb;
   logic rd_stb;
   logic [GATE_N-1:0] gate_hit;
   logic [GATE_N-1:0] gate_wr;
   logic [ADR_W-1:0] gate_ofs [GATE_N];
   logic [ADR_W-1:0] word_adr;

   // Registered ack costs a cycle but keeps every output on a flop
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_stb = req & wb_we_i;
   assign rd_stb = req & ~wb_we_i;
   // Byte lane bits are ignored: every register is one aligned word
   assign word_adr = {wb_adr_i[ADR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
   assign gate_ofs[0] = OFS_RUN_GATE;
   assign gate_ofs[1] = OFS_SLEEP_GATE;
   assign gate_ofs[2] = OFS_DEEP_GATE;

   genvar h;
   generate
      for (h = 0; h < GATE_N; h++) begin : g_hit
         assign gate_hit[h] = (word_adr == gate_ofs[h]);
         assign gate_wr[h] = wr_stb & gate_hit[h];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Gating control words
   // ----------------------------------------------------------------
   logic [DAT_W-1:0] gate_r [GATE_N];
   logic [DAT_W-1:0] gate_eff [GATE_N];
   logic [DAT_W-1:0] gate_rst [GATE_N];

   assign gate_rst[0] = RUN_GATE_RST;
   assign gate_rst[1] = SLEEP_GATE_RST;
   assign gate_rst[2] = DEEP_GATE_RST;

   genvar g;
   genvar b;
   generate
      for (g = 0; g < GATE_N; g++) begin : g_gate
         for (b = 0; b < SEL_W; b++) begin : g_byte
            always_ff @(posedge clk_i) begin
               if (rst_i) begin
                  gate_r[g][b*8 +: 8] <= gate_rst[g][b*8 +: 8];
               end else if (gate_wr[g] && wb_sel_i[b]) begin
                  gate_r[g][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
               end
            end
         end
         dic_gate_mask u_mask (
            .raw_i (gate_r[g]),
            .cap_i (feat_word),
            .eff_o (gate_eff[g])
         );
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_o <= {RUN_GATE_RST, SLEEP_GATE_RST, DEEP_GATE_RST};
      end else begin
         gate_o.run_clock_gate_0 <= gate_eff[0]; // [RULE17]
         gate_o.sleep_clock_gate_0 <= gate_eff[1]; // [RULE17]
         gate_o.deepsleep_clock_gate_0 <= gate_eff[2]; // [RULE17]
      end
   end

   // ----------------------------------------------------------------
   // Read mux and acknowledge
   // ----------------------------------------------------------------
   logic [DAT_W-1:0] rd_nxt;

   // Fixed words have no storage, so a write there is simply dropped
   always_comb begin
      unique case (word_adr)
         OFS_IDENTITY: rd_nxt = id_word; // [RULE20]
         OFS_MEMSIZE: rd_nxt = mem_word; // [RULE20]
         OFS_FEATURE: rd_nxt = feat_word; // [RULE20]
         OFS_RUN_GATE: rd_nxt = gate_eff[0];
         OFS_SLEEP_GATE: rd_nxt = gate_eff[1];
         OFS_DEEP_GATE: rd_nxt = gate_eff[2];
         default: rd_nxt = ZERO_WORD;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= ZERO_WORD;
      end else if (rd_stb) begin
         wb_dat_o <= rd_nxt;
      end
   end

endmodule : dic_regs

// [dic_pkg.sv]
// Package for the device identity and capability register bank.
// Assumes byte addressing on a 32-bit classic Wishbone slave port.
package dic_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int ADR_W = 12;
   localparam int DAT_W = 32;
   localparam int SEL_W = DAT_W / 8;
   localparam logic [ADR_W-1:0] OFS_IDENTITY = 12'h004;
   localparam logic [ADR_W-1:0] OFS_MEMSIZE = 12'h008;
   localparam logic [ADR_W-1:0] OFS_FEATURE = 12'h010;
   localparam logic [ADR_W-1:0] OFS_RUN_GATE = 12'h100;
   localparam logic [ADR_W-1:0] OFS_SLEEP_GATE = 12'h110;
   localparam logic [ADR_W-1:0] OFS_DEEP_GATE = 12'h120;
   localparam int WORD_LSB = 2;

   // ----------------------------------------------------------------
   // Field values
   // ----------------------------------------------------------------
   localparam logic [3:0] FORMAT_VERSION = 4'h0;
   localparam logic [2:0] TEMP_INDUSTRIAL = 3'h1;
   localparam logic [1:0] PKG_QFP48 = 2'h1;
   localparam logic [1:0] QUALIFICATION_STATUS_ENG = 2'b00;
   localparam logic [1:0] QUALIFICATION_STATUS_PILOT = 2'b01;
   localparam logic [1:0] QUALIFICATION_STATUS_FULL = 2'b10;
   localparam logic [15:0] SRAM_4KB = 16'h000F;
   localparam logic [15:0] FLASH_16KB = 16'h0007;
   localparam logic [3:0] MIN_DIV_25MHZ = 4'h7;
   localparam logic [3:0] MAX_RATE_250K = 4'h1;

   // ----------------------------------------------------------------
   // Gating word layout and reset values
   // ----------------------------------------------------------------
   localparam int SPD_LSB = 8;
   localparam int SPD_W = 4;
   localparam logic [DAT_W-1:0] GATE_PASS_MASK = 32'h0011_000F;
   localparam logic [DAT_W-1:0] RUN_GATE_RST = 32'h0000_0000;
   localparam logic [DAT_W-1:0] SLEEP_GATE_RST = 32'h0000_0001;
   localparam logic [DAT_W-1:0] DEEP_GATE_RST = 32'h0000_0001;
   localparam int GATE_N = 3;
   localparam logic [DAT_W-1:0] ZERO_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] format_version;
      logic [3:0] family_code;
      logic [7:0] part_number_code;
      logic [7:0] rsvd;
      logic [2:0] temp_grade;
      logic [1:0] package_code;
      logic substance_compliance_flag;
      logic [1:0] qualification_status;
   } dic_identity_s;

   typedef struct packed {
      logic [15:0] sram_size;
      logic [15:0] flash_size;
   } dic_memsize_s;

   typedef struct packed {
      logic [10:0] rsvd_hi;
      logic pwm_present;
      logic [2:0] rsvd_mid;
      logic adc_present;
      logic [3:0] min_sysclk_divider;
      logic [3:0] max_sample_rate;
      logic mpu_present;
      logic rsvd_lo;
      logic temp_sensor_present;
      logic pll_present;
      logic watchdog_present;
      logic trace_port_present;
      logic swd_port_present;
      logic jtag_port_present;
   } dic_feature_s;

   typedef struct packed {
      logic [DAT_W-1:0] run_clock_gate_0;
      logic [DAT_W-1:0] sleep_clock_gate_0;
      logic [DAT_W-1:0] deepsleep_clock_gate_0;
   } dic_gate_s;

endpackage : dic_pkg

// [dic_gate_mask.sv]
// Effective value of one clock-gating control word.
// Assumes the capability word is constant; purely combinational.
`timescale 1ns/1ps
module dic_gate_mask
   import dic_pkg::*;
(
   // Stored control word and capability word
   input wire logic [DAT_W-1:0] raw_i,
   input wire logic [DAT_W-1:0] cap_i,
   // Word handed to the gating logic
   output logic [DAT_W-1:0] eff_o
);

   logic [SPD_W-1:0] spd;
   logic [SPD_W-1:0] spd_max;
   logic [SPD_W-1:0] spd_clip;
   logic [DAT_W-1:0] spd_word;

   always_comb begin
      spd = raw_i[SPD_LSB +: SPD_W];
      spd_max = cap_i[SPD_LSB +: SPD_W];
      // Clip rather than mask, so a too-high request still runs
      spd_clip = (spd > spd_max) ? spd_max : spd; // [RULE19]
      spd_word = ZERO_WORD;
      spd_word[SPD_LSB +: SPD_W] = spd_clip;
   end

   // Unlisted positions other than the clipped speed field never reach the gating logic
   assign eff_o = (raw_i & cap_i & GATE_PASS_MASK) | spd_word; // [RULE17] [RULE18]

endmodule : dic_gate_mask

// [dic_regs_assertions.sv]
// Checker for the identity and capability register bank.
// Assumes default capabilities; family and part come in by the bind.
`timescale 1ns/1ps
module dic_regs_chk
   import dic_pkg::*;
#(
   parameter logic [3:0] FAMILY = 4'h5, // Arbitrary value
   parameter logic [7:0] PART = 8'h3C // Arbitrary value
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus and gating
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [SEL_W-1:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   input wire logic [DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire dic_gate_s gate_o
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Family and part codes follow the bound bank's own parameters
   localparam logic [DAT_W-1:0] ID = {FORMAT_VERSION, FAMILY, PART,
      8'h00, TEMP_INDUSTRIAL, PKG_QFP48, 1'b1, QUALIFICATION_STATUS_FULL};
   localparam logic [DAT_W-1:0] FEAT = 32'h0011_71BF;
   localparam logic [DAT_W-1:0] M = 32'h0011_0F0F;
   logic req;
   logic rd;
   logic [ADR_W-1:0] wa;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd = req && !wb_we_i;
   assign wa = {wb_adr_i[ADR_W-1:2], 2'b00};
   a_ack_next: assert property (req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_no_stray_ack: assert property (!req |=> !wb_ack_o)
      else $error("ack without request");
   a_identity_read: assert property (rd && wa == OFS_IDENTITY |=>
      wb_dat_o == ID) else $error("identity word wrong");
   a_memsize_read: assert property (rd && wa == OFS_MEMSIZE |=>
      wb_dat_o == {SRAM_4KB, FLASH_16KB}) else $error("memory word wrong");
   a_feature_read: assert property (rd && wa == OFS_FEATURE |=>
      wb_dat_o == FEAT) else $error("feature word wrong");
   a_unmapped_zero: assert property (rd && wa[11:9] != 3'h0 |=>
      wb_dat_o == ZERO_WORD) else $error("unmapped read not zero");
   a_gate_masked: assert property ((gate_o & ~{GATE_N{M}}) == '0)
      else $error("unmasked gating bit passed");
   a_speed_clipped: assert property (
      gate_o.run_clock_gate_0[11:8] <= MAX_RATE_250K &&
      gate_o.sleep_clock_gate_0[11:8] <= MAX_RATE_250K &&
      gate_o.deepsleep_clock_gate_0[11:8] <= MAX_RATE_250K)
      else $error("speed setting above maximum");
   a_gate_update: assert property (
      req && wb_we_i && wb_sel_i == 4'hF && wa == OFS_RUN_GATE &&
      wb_dat_i == 32'hFFFF_FFFF |-> ##2
      gate_o.run_clock_gate_0 == 32'h0011_010F)
      else $error("run gating word wrong after write");
   c_feature: cover property (rd && wa == OFS_FEATURE);
   c_gate_wr: cover property (req && wb_we_i && wa == OFS_DEEP_GATE);
   c_unmapped: cover property (rd && wa[11:9] != 3'h0);
   c_speed_clip: cover property (
      gate_o.sleep_clock_gate_0[11:8] == MAX_RATE_250K);
endmodule : dic_regs_chk

bind dic_regs dic_regs_chk #(.FAMILY(FAMILY), .PART(PART)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gate_o(gate_o));

// [dic_regs_bench.sv]
// Self-checking bench for the identity and capability register bank.
// Assumes default capabilities, own family and part codes, bound checker.
`timescale 1ns/1ps
module dic_regs_bench
   import dic_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   // Family and part differ from the bank's defaults to test the override
   localparam logic [3:0] FAM_CODE = 4'hA; // Arbitrary value
   localparam logic [7:0] PART_CODE = 8'h6D; // Arbitrary value
   localparam logic [DAT_W-1:0] ID_EXP = {FORMAT_VERSION, FAM_CODE,
      PART_CODE, 8'h00, TEMP_INDUSTRIAL, PKG_QFP48, 1'b1, QUALIFICATION_STATUS_FULL};
   localparam logic [DAT_W-1:0] FEAT_EXP = {11'h000, 1'b1, 3'h0, 1'b1,
      MIN_DIV_25MHZ, MAX_RATE_250K, 1'b1, 1'b0, 6'h3F};
   localparam logic [DAT_W-1:0] ALL_EXP = GATE_PASS_MASK | 32'h0000_0100;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [ADR_W-1:0] wb_adr = '0;
   logic [SEL_W-1:0] wb_sel = '0;
   logic [DAT_W-1:0] wb_wdat = '0;
   logic [DAT_W-1:0] wb_rdat;
   logic wb_ack;
   dic_gate_s gate;
   logic [DAT_W-1:0] q;
   int error_cnt = 0;
   int checked = 0;
   logic [ADR_W-1:0] gofs [GATE_N] = '{OFS_RUN_GATE, OFS_SLEEP_GATE,
      OFS_DEEP_GATE};
   logic [DAT_W-1:0] grst [GATE_N] = '{RUN_GATE_RST, SLEEP_GATE_RST,
      DEEP_GATE_RST};
   logic [ADR_W-1:0] rofs [3] = '{OFS_IDENTITY, OFS_MEMSIZE, OFS_FEATURE};
   logic [DAT_W-1:0] rexp [3] = '{ID_EXP, {SRAM_4KB, FLASH_16KB}, FEAT_EXP};

   dic_regs #(.FAMILY(FAM_CODE), .PART(PART_CODE)) DUT (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .gate_o(gate));

   initial forever #25 clk_i = ~clk_i;

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   function automatic logic [DAT_W-1:0] gw(input int i);
      return gate[DAT_W*(GATE_N-1-i) +: DAT_W];
   endfunction : gw

   task automatic check(input string name, input logic [DAT_W-1:0] seen,
      input logic [DAT_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One classic cycle; waits for ack with no assumed latency
   task automatic xfer(input logic w, input logic [ADR_W-1:0] a,
      input logic [SEL_W-1:0] s, input logic [DAT_W-1:0] d);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_sel <= s;
      wb_wdat <= d;
      @(posedge clk_i);
      while (wb_ack !== 1'b1) @(posedge clk_i);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : xfer

   task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e,
      input string name);
      xfer(1'b0, a, 4'h0, 32'h0000_0000);
      check(name, q, e);
   endtask : rd

   task automatic finish_test();
      if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      finish_test();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < GATE_N; i++) begin
         check("gate_rst", gw(i), grst[i]);
      end
      rd(OFS_IDENTITY, ID_EXP, "identity");
      rd(OFS_MEMSIZE, rexp[1], "memsize");
      rd(OFS_FEATURE, FEAT_EXP, "feature");
      // Writes to fixed words must leave every field untouched
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, rofs[i], 4'hF, 32'hFFFF_FFFF);
         rd(rofs[i], rexp[i], "ro_write");
      end
      xfer(1'b1, 12'h200, 4'hF, 32'hFFFF_FFFF);
      rd(12'h200, ZERO_WORD, "unmapped");
      for (int i = 0; i < GATE_N; i++) begin
         xfer(1'b1, gofs[i], 4'hF, 32'hFFFF_FFFF);
         rd(gofs[i], ALL_EXP, "gate_all");
         check("gate_out", gw(i), ALL_EXP);
         xfer(1'b1, gofs[i], 4'hF, 32'h0000_0000);
         rd(gofs[i], ZERO_WORD, "gate_off");
         xfer(1'b1, gofs[i], 4'h2, 32'hFFFF_FFFF);
         rd(gofs[i], 32'h0000_0100, "gate_clip");
         check("gate_clip_out", gw(i), 32'h0000_0100);
      end
      // Reset in mid-run puts every gating word back to its reset value
      xfer(1'b1, OFS_RUN_GATE, 4'hF, 32'hFFFF_FFFF);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < GATE_N; i++) begin
         check("gate_rerst", gw(i), grst[i]);
      end
      rd(OFS_RUN_GATE, RUN_GATE_RST, "run_rerst");
      rd(OFS_SLEEP_GATE, SLEEP_GATE_RST, "sleep_rerst");
      finish_test();
   end
endmodule : dic_regs_bench
